// ===== inc/eiap_consts.svh
// constants of the external interrupt and priority block
`ifndef EIAP_CONSTS_SVH
`define EIAP_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EIAP_OFF_EXT_CFG 8'h00
`define EIAP_OFF_TMR_CTL 8'h04
`define EIAP_OFF_PRIO_SEL 8'h08
`define EIAP_OFF_EXT_PRIO 8'h0c
// ----------------------------------------
// timer control field positions
// ----------------------------------------
`define EIAP_TC_TRIG_A 0
`define EIAP_TC_PEND_A 1
`define EIAP_TC_TRIG_B 2
`define EIAP_TC_PEND_B 3
// ----------------------------------------
// source numbers, reset values and response codes
// ----------------------------------------
`define EIAP_SRC_EXT_A 0
`define EIAP_SRC_EXT_B 2
`define EIAP_RST_EXT_CFG 8'h00
`define EIAP_RST_TMR_CTL 4'h0
`define EIAP_RST_PRIO_SEL 6'h00
`define EIAP_RST_EXT_PRIO 2'h0
`define EIAP_RESP_OKAY 2'h0
`define EIAP_RESP_SLVERR 2'h2
`endif

// ===== inc/eiap_pkg.sv
// types of the external interrupt and priority block
package eiap_pkg;
	// pin select and polarity for both inputs
	typedef struct packed {
		logic b_pol;
		logic [2:0] b_pin;
		logic a_pol;
		logic [2:0] a_pin;
	} eiap_cfg_t;
	// service depth, one-hot
	typedef enum logic [3:0] {
		EIAP_IDLE = 4'h1,
		EIAP_LOW = 4'h2,
		EIAP_HIGH = 4'h4,
		EIAP_NEST = 4'h8
	} eiap_svc_t;
	// request offered to the core
	typedef struct packed {
		logic req;
		logic high;
		logic [2:0] src;
	} eiap_vec_t;
	// events reported by the core
	typedef struct packed {
		logic ack;
		logic [2:0] src;
		logic ret;
		logic instr_done;
	} eiap_cpu_t;
endpackage

// ===== design/eiap_top.sv
// external interrupt inputs, pending flags and two-level priority arbiter
//
// Contract
// RULE_01: per-input polarity bit in config register
// RULE_02: trigger 1 edge/0 level; polarity 1 high
// RULE_03: config field selects each input's port pin
// RULE_04: pins only observed, peripherals left undisturbed
// RULE_05: pending flags at timer control bits 1,3
// RULE_06: edge mode pending clears on vectoring
// RULE_07: level mode pending follows active input
// RULE_08: source holds level until recognized
// RULE_09: source drops level before routine ends
// RULE_10: each source low or high priority
// RULE_11: high request preempts low routine
// RULE_12: nothing preempts a high routine
// RULE_13: priority bits in two registers, reset low
// RULE_14: higher level served first when simultaneous
// RULE_15: equal level uses fixed source order
// RULE_16: sample and decode every clock cycle
// RULE_17: wait for return plus one instruction
// RULE_18: request one cycle after pending flag
// RULE_19: pins synchronised before polarity and edges
`timescale 1ns/1ns
`include "eiap_consts.svh"
module eiap_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// port pins, asynchronous
	input wire logic [7:0] port_pin_in,
	// other interrupt sources, same clock
	input wire logic [7:0] src_req,
	// core handshake
	input wire eiap_pkg::eiap_cfg_t unused_cfg_tie,
	input wire eiap_pkg::eiap_cpu_t cpu_in,
	output eiap_pkg::eiap_vec_t vec_out
);
	import eiap_pkg::*;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	eiap_cfg_t ext_irq_config_reg;
	logic [1:0] trig_type_reg;
	logic [1:0] pending_reg;
	logic [5:0] priority_select_reg;
	logic [1:0] ext_priority_reg;
	eiap_svc_t svc_reg;
	eiap_svc_t svc_next;
	logic ret_hold_reg;
	eiap_vec_t vec_reg;
	eiap_vec_t vec_next;

	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] awaddr_reg;
	logic [7:0] wbyte_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// reset to high so an idle pulled-up pin does not look like an edge
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 8'hff;
			pin_s2_reg <= 8'hff;
		end else begin
			pin_s1_reg <= port_pin_in; // RULE_19
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ----------------------------------------
	// input select, polarity and edge detect
	// ----------------------------------------
	// the pins are read only, so any crossbar owner keeps its pin
	wire [2:0] pin_sel [2];
	wire [1:0] pol;
	wire [1:0] raw;
	wire [1:0] act;
	wire [1:0] rise;
	wire [1:0] sw_pend_wr;
	wire [1:0] sw_pend_val;
	wire [1:0] svc_clr;
	logic [1:0] act_prev_reg;
	logic [1:0] pending_next;

	assign pin_sel[0] = ext_irq_config_reg.a_pin; // RULE_03
	assign pin_sel[1] = ext_irq_config_reg.b_pin; // RULE_03
	assign pol = {ext_irq_config_reg.b_pol, ext_irq_config_reg.a_pol}; // RULE_01
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_ext
			localparam logic [2:0] SRC = (k == 0) ? 3'(`EIAP_SRC_EXT_A) : 3'(`EIAP_SRC_EXT_B);
			assign raw[k] = pin_s2_reg[pin_sel[k]]; // RULE_04
			assign act[k] = pol[k] ? raw[k] : ~raw[k]; // RULE_02
			assign rise[k] = act[k] & ~act_prev_reg[k];
			assign svc_clr[k] = cpu_in.ack & (cpu_in.src == SRC); // RULE_06
			always_comb begin
				if (trig_type_reg[k]) begin
					// a fresh edge beats a clear in the same cycle
					pending_next[k] = rise[k] |
						((sw_pend_wr[k] ? sw_pend_val[k] : pending_reg[k]) & ~svc_clr[k]); // RULE_06
				end else begin
					pending_next[k] = act[k]; // RULE_07
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_prev_reg <= 2'h0;
			pending_reg <= 2'h0;
		end else begin
			act_prev_reg <= act;
			pending_reg <= pending_next; // RULE_16
		end
	end

	// ----------------------------------------
	// priority decode
	// ----------------------------------------
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	wire [7:0] req_all;
	wire [7:0] prio_all;
	wire [7:0] hi_set;
	wire [7:0] lo_set;
	wire allow_hi;
	wire allow_lo;
	wire take_hi;
	wire take_lo;
	wire ack_high;

	assign req_all = {src_req[7:3], pending_reg[1], src_req[1], pending_reg[0]};
	assign prio_all = {ext_priority_reg, priority_select_reg}; // RULE_10
	assign hi_set = req_all & prio_all;
	assign lo_set = req_all & ~prio_all;
	// after a return the core must finish one more instruction first
	assign allow_hi = (svc_reg == EIAP_IDLE || svc_reg == EIAP_LOW) && !ret_hold_reg; // RULE_11
	assign allow_lo = (svc_reg == EIAP_IDLE) && !ret_hold_reg; // RULE_17
	assign take_hi = allow_hi && (|hi_set); // RULE_14
	assign take_lo = allow_lo && (|lo_set) && !take_hi;
	assign ack_high = prio_all[cpu_in.src];

	always_comb begin
		vec_next.req = (take_hi | take_lo) & ~cpu_in.ack; // RULE_18
		vec_next.high = take_hi;
		vec_next.src = take_hi ? first_set(hi_set) : first_set(lo_set); // RULE_15
	end

	// ----------------------------------------
	// service depth
	// ----------------------------------------
	always_comb begin
		svc_next = svc_reg;
		case (svc_reg)
			EIAP_IDLE: begin
				if (cpu_in.ack) begin
					svc_next = ack_high ? EIAP_HIGH : EIAP_LOW;
				end
			end
			EIAP_LOW: begin
				if (cpu_in.ack && ack_high) begin
					svc_next = EIAP_NEST; // RULE_11
				end else if (cpu_in.ret) begin
					svc_next = EIAP_IDLE;
				end
			end
			EIAP_HIGH: begin
				if (cpu_in.ret) begin
					svc_next = EIAP_IDLE; // RULE_12
				end
			end
			EIAP_NEST: begin
				if (cpu_in.ret) begin
					svc_next = EIAP_LOW;
				end
			end
			default: begin
				svc_next = EIAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			svc_reg <= EIAP_IDLE;
			ret_hold_reg <= 1'b0;
			vec_reg <= '0;
		end else begin
			svc_reg <= svc_next;
			ret_hold_reg <= cpu_in.ret | (ret_hold_reg & ~cpu_in.instr_done); // RULE_17
			vec_reg <= vec_next; // RULE_16
		end
	end

	// ----------------------------------------
	// bus write path
	// ----------------------------------------
	wire aw_take;
	wire w_take;
	wire wr_do;
	wire wr_cfg;
	wire wr_tc;
	wire wr_ps;
	wire wr_ep;
	wire wr_hit;
	wire aw_have_next;
	wire w_have_next;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_do = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign aw_have_next = (aw_have_reg & ~wr_do) | aw_take;
	assign w_have_next = (w_have_reg & ~wr_do) | w_take;
	assign wr_cfg = awaddr_reg == `EIAP_OFF_EXT_CFG;
	assign wr_tc = awaddr_reg == `EIAP_OFF_TMR_CTL;
	assign wr_ps = awaddr_reg == `EIAP_OFF_PRIO_SEL;
	assign wr_ep = awaddr_reg == `EIAP_OFF_EXT_PRIO;
	assign wr_hit = wr_cfg | wr_tc | wr_ps | wr_ep;
	assign sw_pend_wr = {2{wr_do & wr_tc & wstrb0_reg}};
	assign sw_pend_val = {wbyte_reg[`EIAP_TC_PEND_B], wbyte_reg[`EIAP_TC_PEND_A]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awaddr_reg <= 8'h00;
			wbyte_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `EIAP_RESP_OKAY;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			s_axi_awready <= ~aw_have_next;
			s_axi_wready <= ~w_have_next;
			if (aw_take) begin
				awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (w_take) begin
				wbyte_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `EIAP_RESP_OKAY : `EIAP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// software-written control
	// ----------------------------------------
	// only byte lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq_config_reg <= `EIAP_RST_EXT_CFG;
			trig_type_reg <= 2'h0;
			priority_select_reg <= `EIAP_RST_PRIO_SEL; // RULE_13
			ext_priority_reg <= `EIAP_RST_EXT_PRIO; // RULE_13
		end else if (wr_do && wstrb0_reg) begin
			if (wr_cfg) begin
				ext_irq_config_reg <= wbyte_reg; // RULE_01
			end
			if (wr_tc) begin
				trig_type_reg <= {wbyte_reg[`EIAP_TC_TRIG_B], wbyte_reg[`EIAP_TC_TRIG_A]}; // RULE_02
			end
			if (wr_ps) begin
				priority_select_reg <= wbyte_reg[5:0]; // RULE_13
			end
			if (wr_ep) begin
				ext_priority_reg <= wbyte_reg[1:0]; // RULE_13
			end
		end
	end

	// ----------------------------------------
	// bus read path
	// ----------------------------------------
	wire ar_take;
	wire [7:0] rd_addr;
	wire [7:0] tc_view;
	wire rd_hit;
	wire [7:0] rd_byte;

	assign ar_take = s_axi_arvalid & arready_reg;
	assign rd_addr = {s_axi_araddr[7:2], 2'h0};
	assign tc_view = {4'h0, pending_reg[1], trig_type_reg[1], pending_reg[0], trig_type_reg[0]}; // RULE_05
	assign rd_hit = rd_addr == `EIAP_OFF_EXT_CFG || rd_addr == `EIAP_OFF_TMR_CTL ||
		rd_addr == `EIAP_OFF_PRIO_SEL || rd_addr == `EIAP_OFF_EXT_PRIO;
	assign rd_byte = (rd_addr == `EIAP_OFF_EXT_CFG) ? ext_irq_config_reg :
		(rd_addr == `EIAP_OFF_TMR_CTL) ? tc_view :
		(rd_addr == `EIAP_OFF_PRIO_SEL) ? {2'h0, priority_select_reg} :
		(rd_addr == `EIAP_OFF_EXT_PRIO) ? {6'h00, ext_priority_reg} : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `EIAP_RESP_OKAY;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h00_0000, rd_byte};
			rresp_reg <= rd_hit ? `EIAP_RESP_OKAY : `EIAP_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign vec_out = vec_reg;
endmodule

// ===== verification/eiap_monitor.sv
// concurrent checks on the interrupt block's ports
`timescale 1ns/1ns
module eiap_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core side
	input wire eiap_pkg::eiap_cpu_t cpu_in,
	input wire eiap_pkg::eiap_vec_t vec_out
);
	import eiap_pkg::*;
	logic hi_q;
	logic lo_q;
	logic hold_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// service depth rebuilt from core pulses
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			// inner return closes the high level first
			if (cpu_in.ack && vec_out.high)
				hi_q <= 1'b1;
			else if (cpu_in.ret && hi_q)
				hi_q <= 1'b0;
			if (cpu_in.ack && !vec_out.high)
				lo_q <= 1'b1;
			else if (cpu_in.ret && !hi_q)
				lo_q <= 1'b0;
			hold_q <= cpu_in.ret | (hold_q & ~cpu_in.instr_done);
		end
	end
	a_ack_drops_req: assert property (cpu_in.ack |=> !vec_out.req)
		else $error("request still up after acknowledge");
	a_high_not_preempted: assert property (hi_q |-> !vec_out.req)
		else $error("request during high routine");
	a_low_only_high: assert property (lo_q && !hi_q && vec_out.req |-> vec_out.high)
		else $error("low request during low routine");
	a_return_waits: assert property (hold_q |-> !vec_out.req)
		else $error("request before return and next instruction");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_bresp_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	c_nested: cover property (lo_q && hi_q);
	c_high_req: cover property (vec_out.req && vec_out.high);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== verification/eiap_pin_src.sv
// port pins driven by outside interrupt sources
`timescale 1ns/1ns
module eiap_pin_src #(
	parameter int DLY = 13
) (
	// levels asked for by the bench
	input wire logic [7:0] want,
	// pins toward the device
	output logic [7:0] pins
);
	// ----------------------------------------
	// sources
	// ----------------------------------------
	// skewed off the clock edge, the pins are asynchronous to the device
	initial pins = 8'hff;
	always @(want) pins <= #DLY want;
endmodule

// ===== verification/testbench.sv
// self-checking bench for the interrupt block
`timescale 1ns/1ns
`include "eiap_consts.svh"
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
	import eiap_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, port_pin_in, src_req, pin_want;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] p;
	logic req_d;
	logic lane0;
	logic [33:0] bq[$];
	logic [3:0] vq[$];
	int mismatches = 0;
	int n_checks = 0;
	eiap_cfg_t unused_cfg_tie;
	eiap_cpu_t cpu_in;
	eiap_vec_t vec_out;
	eiap_top eiap_top_inst (.*);
	eiap_pin_src eiap_pin_src_inst (.want(pin_want), .pins(port_pin_in));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		bq.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= {3'($urandom), lane0};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		bq.push_back({r, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input eiap_cpu_t c);
		@(posedge aclk);
		cpu_in <= c;
		unused_cfg_tie <= 8'($urandom);
		@(posedge aclk);
		cpu_in <= '0;
	endtask
	// core vectors to whatever is offered
	task automatic take;
		int n;
		n = 0;
		while (vec_out.req !== 1'b1 && n < 60) begin
			@(posedge aclk);
			n++;
		end
		pulse({1'b1, vec_out.src, 2'b00});
	endtask
	task automatic fin;
		pulse(6'h02);
		repeat (2) @(posedge aclk);
		pulse(6'h01);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge aclk) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			`CHK({s_axi_bresp, 32'h0}, bq.pop_front(), "write response")
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			`CHK({s_axi_rresp, s_axi_rdata}, bq.pop_front(), "read data")
		if (vec_out.req === 1'b1 && req_d !== 1'b1)
			`CHK({vec_out.high, vec_out.src}, vq.pop_front(), "vector")
		req_d <= vec_out.req;
	end
	initial begin
		#2000000;
		mismatches++;
		end_sim;
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, src_req, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hf;
		pin_want = 8'hff;
		unused_cfg_tie = '0;
		cpu_in = '0;
		req_d = 1'b0;
		lane0 = 1'b1;
		void'($urandom(76056));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++)
			rd(8'(4 * i), 8'h00, `EIAP_RESP_OKAY);
		rd(8'h10, 8'h00, `EIAP_RESP_SLVERR);
		wr(8'h10, 8'hff, `EIAP_RESP_SLVERR);
		p = 3'($urandom);
		wr(`EIAP_OFF_PRIO_SEL, 8'hff, `EIAP_RESP_OKAY);
		rd(`EIAP_OFF_PRIO_SEL, 8'h3f, `EIAP_RESP_OKAY);
		wr(`EIAP_OFF_EXT_PRIO, 8'hff, `EIAP_RESP_OKAY);
		rd(`EIAP_OFF_EXT_PRIO, 8'h03, `EIAP_RESP_OKAY);
		// byte lane 0 off: the write is answered but leaves the register alone
		lane0 = 1'b0;
		wr(`EIAP_OFF_PRIO_SEL, 8'h00, `EIAP_RESP_OKAY);
		rd(`EIAP_OFF_PRIO_SEL, 8'h3f, `EIAP_RESP_OKAY);
		lane0 = 1'b1;
		wr(`EIAP_OFF_PRIO_SEL, 8'h00, `EIAP_RESP_OKAY);
		wr(`EIAP_OFF_EXT_PRIO, 8'h00, `EIAP_RESP_OKAY);
		$display("test registers done");
		// a falls edge-sensitive on pin p; b waits level-low on an idle pin
		wr(`EIAP_OFF_EXT_CFG, {1'b0, p ^ 3'h2, 1'b0, p}, `EIAP_RESP_OKAY);
		wr(`EIAP_OFF_TMR_CTL, 8'hf1, `EIAP_RESP_OKAY);
		pin_want[p ^ 3'h1] <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(`EIAP_OFF_TMR_CTL, 8'h01, `EIAP_RESP_OKAY);
		vq.push_back(4'h0);
		pin_want[p] <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(`EIAP_OFF_TMR_CTL, 8'h03, `EIAP_RESP_OKAY);
		take;
		rd(`EIAP_OFF_TMR_CTL, 8'h01, `EIAP_RESP_OKAY);
		fin;
		$display("test edge done");
		// b active high, level, same pin: rising pin is no edge for a
		wr(`EIAP_OFF_EXT_CFG, {1'b1, p, 1'b0, p}, `EIAP_RESP_OKAY);
		vq.push_back(4'h2);
		pin_want[p] <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(`EIAP_OFF_TMR_CTL, 8'h09, `EIAP_RESP_OKAY);
		take;
		rd(`EIAP_OFF_TMR_CTL, 8'h09, `EIAP_RESP_OKAY);
		pin_want[p] <= 1'b0;
		repeat (6) @(posedge aclk);
		wr(`EIAP_OFF_TMR_CTL, 8'h0b, `EIAP_RESP_OKAY);
		rd(`EIAP_OFF_TMR_CTL, 8'h03, `EIAP_RESP_OKAY);
		vq.push_back(4'h0);
		fin;
		take;
		rd(`EIAP_OFF_TMR_CTL, 8'h01, `EIAP_RESP_OKAY);
		fin;
		$display("test level done");
		// a edge active high on pin p; b level active low on pin p^1, already low
		wr(`EIAP_OFF_EXT_CFG, {1'b0, p ^ 3'h1, 1'b1, p}, `EIAP_RESP_OKAY);
		vq.push_back(4'h2);
		take;
		pin_want <= 8'hff;
		repeat (6) @(posedge aclk);
		rd(`EIAP_OFF_TMR_CTL, 8'h03, `EIAP_RESP_OKAY);
		vq.push_back(4'h0);
		fin;
		take;
		fin;
		$display("test polarity done");
		// sources 1,3,5 at once, 3 high; slots 0 and 2 carry noise
		wr(`EIAP_OFF_PRIO_SEL, 8'h08, `EIAP_RESP_OKAY);
		vq.push_back(4'hb);
		src_req <= 8'h2a | (8'($urandom) & 8'h05);
		take;
		src_req[3] <= 1'b0;
		vq.push_back(4'h1);
		fin;
		take;
		src_req[1] <= 1'b0;
		vq.push_back(4'hb);
		@(posedge aclk);
		src_req[3] <= 1'b1;
		take;
		src_req[3] <= 1'b0;
		fin;
		repeat (8) @(posedge aclk);
		vq.push_back(4'h5);
		fin;
		take;
		src_req[5] <= 1'b0;
		fin;
		repeat (8) @(posedge aclk);
		`CHK(vq.size(), 0, "vector missing")
		$display("test priority done");
		end_sim;
	end
endmodule
bind eiap_top eiap_monitor eiap_monitor_inst (.*);
